// ### hdl/cics_host.sv
// bus master that reads and writes the charger's command registers
//
// Overview of operation
// - access is word write or word read: select register, then move data; the host also moves a single byte when cmd_two is 0.
// - bus runs up to 100 kbit/s standard or 400 kbit/s fast.
// - both lines are open drain, pulled low or released, idle high.
// - data changes only while clock is low, one clock pulse per bit.
// - START is data falling with clock high, STOP data rising.
// - only the master makes START and STOP; busy between them.
// - bytes are 8 bits, MSB first, each followed by one acknowledge.
// - slave may hold clock low; master waits for its release.
// - master makes every clock pulse, the ninth acknowledge pulse too.
// - transmitter releases data on ninth clock, receiver pulls it low.
// - data high on ninth clock is NACK; master then stops or restarts.
// - first byte after START is 7-bit address plus direction bit.
// - two-byte settings written low byte then high, nothing between.
`timescale 1ns/1ps
`default_nettype none
module cics_host
  import cics_pkg::*;
(
  input wire logic clk, // system clock, 20 MHz
  input wire logic nrst, // async reset, active low
  input wire logic fast_mode, // 1 selects the fast bus rate
  input wire logic cmd_valid, // command offered
  output logic cmd_ready, // command taken when both high
  input wire logic cmd_read, // 1 read, 0 write
  input wire logic cmd_two, // 1 moves two bytes, 0 one byte
  input wire logic [7:0] cmd_reg, // register address in the far device
  input wire logic [15:0] cmd_wdata, // write data, low byte sent first
  output logic rsp_valid, // one-cycle end of command
  output logic rsp_nack, // a byte was not acknowledged
  output logic rsp_err, // command refused without bus traffic
  output logic [15:0] rsp_rdata, // read data, first byte in the low half
  output logic busy, // a transfer is under way
  input wire logic scl_in, // clock line level
  output logic scl_out, // clock line drive value
  output logic scl_oe_n, // clock line pulled low while 0
  input wire logic sda_in, // data line level
  output logic sda_out, // data line drive value
  output logic sda_oe_n // data line pulled low while 0
);
  cics_state_t state;
  cics_seg_t seg;
  logic [1:0] phase;
  logic [QCNT_W-1:0] qcnt;
  logic [QCNT_W-1:0] qload;
  logic q_done;
  logic step;
  logic scl_drive;
  logic sda_drive;
  logic scl_s;
  logic sda_s;
  logic [7:0] shift;
  logic [3:0] bitn;
  logic ack_high;
  logic nack;
  logic byte_hi;
  logic read_q;
  logic two_q;
  logic [7:0] reg_q;
  logic [15:0] wdata_q;
  logic more_bytes;
  logic refuse;

  // low byte of a two-byte setting
  function automatic logic pair_low(input logic [7:0] a);
    pair_low = (a == CHARGE_CURRENT_SETTING) || (a == CHARGE_VOLTAGE_LIMIT_SETTING) ||
               (a == REVERSE_OUTPUT_VOLTAGE_SETTING) || (a == INPUT_VOLTAGE_SETTING) ||
               (a == INPUT_CURRENT_LIMIT_IN_USE);
  endfunction

  // high byte of a two-byte setting: the odd neighbour of a low byte
  function automatic logic pair_high(input logic [7:0] a);
    pair_high = a[0] && pair_low({a[7:1], 1'b0});
  endfunction

  cics_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  assign scl_out = PIN_LOW;
  assign sda_out = PIN_LOW;
  assign scl_oe_n = !scl_drive;
  assign sda_oe_n = !sda_drive;
  assign cmd_ready = (state == ST_IDLE);
  assign busy = (state != ST_IDLE);
  assign rsp_rdata = wdata_q;
  assign qload = fast_mode ? QUARTER_FAST : QUARTER_STD;
  assign q_done = (qcnt == QCNT_ZERO);
  // the rising phase also waits for the line itself, so a held clock stalls us
  assign step = q_done && (phase != P_RISE || scl_s);
  assign more_bytes = two_q && !byte_hi;
  // a lone high byte or a half setting would be dropped by the far device
  assign refuse = !cmd_read &&
                  (pair_high(cmd_reg) || (pair_low(cmd_reg) && !cmd_two));

  // quarter-bit timer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      qcnt <= QUARTER_STD;
    end else if (state == ST_IDLE || step) begin
      qcnt <= qload;
    end else if (!q_done) begin
      qcnt <= qcnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= P_LOW;
    end else if (state == ST_IDLE) begin
      phase <= P_LOW;
    end else if (step) begin
      phase <= phase + 1'b1;
    end
  end

  // clock line: the host alone makes every pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_drive <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: scl_drive <= 1'b0;
        ST_START: begin
          if (phase != P_LOW) begin
            scl_drive <= (phase == P_FALL);
          end
        end
        ST_BIT: scl_drive <= (phase == P_LOW) || (phase == P_FALL);
        ST_STOP: scl_drive <= (phase == P_LOW);
      endcase
    end
  end

  // data line: changes only in the low phase, except START and STOP edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_drive <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: sda_drive <= 1'b0;
        ST_START: sda_drive <= phase[1];
        ST_BIT: begin
          if (phase == P_LOW) begin
            if (bitn != ACK_SLOT) begin
              sda_drive <= (seg != SEG_RDATA) && !shift[7];
            end else begin
              // master acks every read byte but the last, released on writes
              sda_drive <= (seg == SEG_RDATA) && more_bytes;
            end
          end
        end
        ST_STOP: sda_drive <= !phase[1];
      endcase
    end
  end

  // response strobe and flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == ST_IDLE && cmd_valid && refuse) begin
        rsp_valid <= 1'b1;
        rsp_err <= 1'b1;
        rsp_nack <= 1'b0;
      end else if (state == ST_STOP && step && phase == P_FALL) begin
        rsp_valid <= 1'b1;
        rsp_err <= 1'b0;
        rsp_nack <= nack;
      end
    end
  end

  // transaction sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      seg <= SEG_ADDR_W;
      shift <= 8'h00;
      bitn <= BIT_FIRST;
      ack_high <= 1'b0;
      nack <= 1'b0;
      byte_hi <= 1'b0;
      read_q <= 1'b0;
      two_q <= 1'b0;
      reg_q <= 8'h00;
      wdata_q <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_valid && !refuse) begin
            state <= ST_START;
            seg <= SEG_ADDR_W;
            shift <= {SLAVE_ADDR, DIR_WRITE};
            bitn <= BIT_FIRST;
            nack <= 1'b0;
            byte_hi <= 1'b0;
            read_q <= cmd_read;
            two_q <= cmd_two;
            reg_q <= cmd_reg;
            wdata_q <= cmd_read ? 16'h0000 : cmd_wdata;
          end
        end
        ST_START: begin
          if (step && phase == P_FALL) begin
            state <= ST_BIT;
            bitn <= BIT_FIRST;
          end
        end
        ST_BIT: begin
          if (step && phase == P_HIGH) begin
            if (bitn != ACK_SLOT) begin
              shift <= {shift[6:0], sda_s};
            end else begin
              ack_high <= sda_s;
            end
          end
          if (step && phase == P_FALL) begin
            if (bitn != ACK_SLOT) begin
              bitn <= bitn + 1'b1;
            end else begin
              bitn <= BIT_FIRST;
              if (seg != SEG_RDATA && ack_high) begin
                // an unknown register also ends here, with a NACK
                nack <= 1'b1;
                state <= ST_STOP;
              end else begin
                unique case (seg)
                  SEG_ADDR_W: begin
                    seg <= SEG_REG;
                    shift <= reg_q;
                  end
                  SEG_REG: begin
                    if (read_q) begin
                      seg <= SEG_ADDR_R;
                      shift <= {SLAVE_ADDR, DIR_READ};
                      state <= ST_START;
                    end else begin
                      seg <= SEG_WDATA;
                      shift <= wdata_q[7:0];
                    end
                  end
                  SEG_WDATA: begin
                    // both halves go in one burst, far inside any watchdog period
                    if (more_bytes) begin
                      byte_hi <= 1'b1;
                      shift <= wdata_q[15:8];
                    end else begin
                      state <= ST_STOP;
                    end
                  end
                  SEG_ADDR_R: seg <= SEG_RDATA;
                  SEG_RDATA: begin
                    if (byte_hi) begin
                      wdata_q[15:8] <= shift;
                    end else begin
                      wdata_q[7:0] <= shift;
                    end
                    if (more_bytes) begin
                      byte_hi <= 1'b1;
                    end else begin
                      state <= ST_STOP;
                    end
                  end
                endcase
              end
            end
          end
        end
        ST_STOP: begin
          if (step && phase == P_FALL) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_write_ack_nack;
    state == ST_BIT && bitn == ACK_SLOT && phase == P_FALL && step &&
      seg != SEG_RDATA && ack_high;
  endsequence

  sequence s_stop_entered;
    state == ST_STOP && phase == P_LOW;
  endsequence

  a_sda_stable_high: assert property (
    (state == ST_BIT && phase != P_LOW && $past(state) == ST_BIT && $past(phase) != P_LOW)
      |-> $stable(sda_drive))
    else $error("data line moved while clock released");

  a_addr_byte_first: assert property (
    (state == ST_BIT && $past(state) == ST_START) |-> shift[7:1] == SLAVE_ADDR)
    else $error("first byte after start is not the slave address");

  a_start_edge: assert property (
    (state == ST_START && phase == P_HIGH && $past(phase) == P_HIGH)
      |-> (!scl_drive && sda_drive))
    else $error("start not made with clock released");

  a_idle_bus_free: assert property (
    (state == ST_IDLE && $past(state) == ST_IDLE) |-> (!scl_drive && !sda_drive))
    else $error("bus line held while idle");

  a_ack_slot_release: assert property (
    (state == ST_BIT && bitn == ACK_SLOT && seg != SEG_RDATA && phase == P_HIGH)
      |-> !sda_drive)
    else $error("host held data during slave acknowledge");

  a_read_ack_last: assert property (
    (state == ST_BIT && bitn == ACK_SLOT && seg == SEG_RDATA && phase == P_HIGH)
      |-> (sda_drive == more_bytes))
    else $error("wrong acknowledge on read byte");

  a_nack_then_stop: assert property (
    s_write_ack_nack |=> s_stop_entered)
    else $error("no stop after not-acknowledge");

  a_stretch_wait: assert property (
    (state == ST_BIT && phase == P_RISE && !scl_s) |=> (state == ST_BIT && phase == P_RISE))
    else $error("host ran on while clock held low");

  a_quarter_gap: assert property (
    (state != ST_IDLE && $past(state) != ST_IDLE && phase != $past(phase)) |-> $past(q_done))
    else $error("bit phase shorter than a quarter period");

  a_pair_refused: assert property (
    (cmd_valid && cmd_ready && !cmd_read && pair_high(cmd_reg))
      |=> (rsp_valid && rsp_err && state == ST_IDLE))
    else $error("high byte write without low byte went out");

  a_byte_nine_bits: assert property (
    (state == ST_BIT && bitn == ACK_SLOT && phase == P_FALL && step) |=> bitn == BIT_FIRST)
    else $error("byte framing not nine clocks");
endmodule
`default_nettype wire

// ### common/cics_pkg.sv
// constants shared by the two-wire command host and its pin synchroniser
`default_nettype none
package cics_pkg;
  // system clock and bus rates
  localparam int CLK_HZ = 20_000_000;
  localparam int STD_RATE_HZ = 100_000;
  localparam int FAST_RATE_HZ = 400_000;
  localparam int PHASES_PER_BIT = 4;
  // each bit is four equal phases; round up so the bus never runs over its rate
  localparam int QUARTER_STD_INT =
    (CLK_HZ + PHASES_PER_BIT * STD_RATE_HZ - 1) / (PHASES_PER_BIT * STD_RATE_HZ);
  localparam int QUARTER_FAST_INT =
    (CLK_HZ + PHASES_PER_BIT * FAST_RATE_HZ - 1) / (PHASES_PER_BIT * FAST_RATE_HZ);
  localparam int QCNT_W = 8;
  localparam logic [QCNT_W-1:0] QUARTER_STD = QCNT_W'(QUARTER_STD_INT - 1);
  localparam logic [QCNT_W-1:0] QUARTER_FAST = QCNT_W'(QUARTER_FAST_INT - 1);
  localparam logic [QCNT_W-1:0] QCNT_ZERO = 8'h00;

  // addressing of the far device
  localparam logic [6:0] SLAVE_ADDR = 7'h6D;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // map of the far device: low byte offsets of the two-byte settings, then the two code registers
  localparam logic [7:0] CHARGE_CURRENT_SETTING = 8'h02;
  localparam logic [7:0] CHARGE_VOLTAGE_LIMIT_SETTING = 8'h04;
  localparam logic [7:0] REVERSE_OUTPUT_VOLTAGE_SETTING = 8'h06;
  localparam logic [7:0] INPUT_VOLTAGE_SETTING = 8'h0A;
  localparam logic [7:0] INPUT_CURRENT_LIMIT_IN_USE = 8'h24;
  localparam logic [7:0] MAKER_CODE_REGISTER = 8'h2E;
  localparam logic [7:0] PART_CODE_REGISTER = 8'h2F;

  // bit framing
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] P_LOW = 2'h0;
  localparam logic [1:0] P_RISE = 2'h1;
  localparam logic [1:0] P_HIGH = 2'h2;
  localparam logic [1:0] P_FALL = 2'h3;
  localparam logic PIN_LOW = 1'b0;
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} cics_state_t;
  typedef enum logic [2:0] {SEG_ADDR_W, SEG_REG, SEG_WDATA, SEG_ADDR_R, SEG_RDATA} cics_seg_t;
endpackage
`default_nettype wire

// ### hdl/cics_sync.sv
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module cics_sync
  import cics_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // levels safe for logic
);
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // released bus lines rest high, so reset to the idle level
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta[i] <= PIN_IDLE;
          sync_out[i] <= PIN_IDLE;
        end else begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### bench/cics_dev_model.sv
// behavioural charger device answering on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module cics_dev_model #(
  parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] PART = 8'hA5, // arbitrary value
  parameter logic [39:0] WDOG_NS = 40'h28_BED0_1600 // pair gap limit, 175 s in ns
) (
  input wire logic lclk, // model clock, times the clock stretch
  input wire logic scl, // clock line level
  input wire logic sda, // data line level
  input wire logic [3:0] stretch, // units of four lclk cycles to hold the clock low per byte
  output logic scl_oe_n, // clock line pulled low while 0
  output logic sda_oe_n // data line pulled low while 0
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, tx, ptr, pend, pend_at;
  logic [3:0] cnt;
  logic [1:0] ph; // 0 address, 1 register, 2 data, 3 idle
  logic rd, go_rd, pend_ok, ack;
  realtime pend_t;
  function automatic logic known(input logic [7:0] a);
    return a <= 8'h0F || (a >= 8'h20 && a <= 8'h3B);
  endfunction
  task automatic put(input logic [7:0] d);
    if (ptr inside {8'h02, 8'h04, 8'h06, 8'h0A, 8'h24}) begin
      pend = d;
      pend_at = ptr;
      pend_ok = 1'b1;
      pend_t = $realtime;
    end else if (ptr inside {8'h03, 8'h05, 8'h07, 8'h0B, 8'h25}) begin
      // a low byte older than the watchdog period is dropped with its high byte
      if (pend_ok && pend_at == ptr - 8'd1 &&
          ($realtime - pend_t) <= WDOG_NS) begin
        mem[pend_at] = pend;
        mem[ptr] = d;
      end
      pend_ok = 1'b0;
    end else begin
      // status and code registers are read only
      if (ptr < 8'h20 || ptr > 8'h2F) mem[ptr] = d;
      pend_ok = 1'b0;
    end
    ptr = ptr + 8'd1;
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h2E] = MAKER;
    mem[8'h2F] = PART;
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    ph = 2'd3;
    cnt = 4'd0;
    rd = 1'b0;
    go_rd = 1'b0;
    pend_ok = 1'b0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    ph = 2'd0;
    cnt = 4'd0;
    rd = 1'b0;
    go_rd = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) ph = 2'd3;
  always @(posedge scl) if (ph != 2'd3) begin
    cnt = cnt + 4'd1;
    if (cnt <= 4'd8 && !rd) sh = {sh[6:0], sda};
    if (cnt == 4'd9 && rd) begin
      if (sda) ph = 2'd3;
      else begin
        tx = mem[ptr];
        ptr = ptr + 8'd1;
      end
    end
  end
  always @(negedge scl) if (ph != 2'd3) begin
    if (cnt == 4'd8) begin
      if (rd) sda_oe_n = 1'b1;
      else begin
        ack = 1'b1;
        if (ph == 2'd0) begin
          ack = sh[7:1] == 7'h6D;
          go_rd = ack & sh[0];
          ph = !ack ? 2'd3 : sh[0] ? 2'd2 : 2'd1;
        end else if (ph == 2'd1) begin
          ack = known(sh);
          ptr = sh;
          ph = ack ? 2'd2 : 2'd3;
        end else put(sh);
        sda_oe_n = !ack;
      end
    end else if (cnt == 4'd9) begin
      cnt = 4'd0;
      sda_oe_n = 1'b1;
      if (go_rd) begin
        rd = 1'b1;
        go_rd = 1'b0;
        tx = mem[ptr];
        ptr = ptr + 8'd1;
      end
      if (rd) sda_oe_n = tx[7];
      if (stretch != 4'd0) begin
        scl_oe_n = 1'b0;
        // outlasts the host's own low time in fast mode only from stretch 7 up; at stretch 5 it is shorter
        repeat (4 * stretch) @(posedge lclk);
        scl_oe_n = 1'b1;
      end
    end else if (rd) sda_oe_n = tx[7 - cnt];
  end
endmodule
`default_nettype wire

// ### bench/cics_host_tb.sv
// self-checking bench for the two-wire command host
`timescale 1ns/1ps
`default_nettype none
module cics_host_tb;
  import cics_pkg::*;
  typedef struct packed {
    logic nack;
    logic err;
    logic [15:0] rd;
    logic [15:0] mask;
    logic [1:0] st;
    logic [7:0] pulses;
  } cics_exp_t;
  localparam logic [7:0] MAKER_V = 8'h5A; // arbitrary value
  localparam logic [7:0] PART_V = 8'hA5; // arbitrary value
  logic clk, lclk, nrst, fast_mode, cmd_valid, cmd_read, cmd_two;
  logic [7:0] cmd_reg;
  logic [15:0] cmd_wdata, rsp_rdata, d;
  logic [15:0] kept [4];
  logic [3:0] stretch;
  logic cmd_ready, rsp_valid, rsp_nack, rsp_err, busy;
  logic scl_oe_n, sda_oe_n, dscl_oe_n, dsda_oe_n, scl_o, sda_o;
  // a host pin pulls low only with its enable on and its drive value low
  wire logic scl = (scl_oe_n | scl_o) & dscl_oe_n;
  wire logic sda = (sda_oe_n | sda_o) & dsda_oe_n;
  cics_exp_t exp_q [$];
  cics_exp_t e;
  int err_total, total_checks, cycles, rsp_cnt, starts, pulses;
  logic [7:0] pair [4] = '{CHARGE_CURRENT_SETTING, CHARGE_VOLTAGE_LIMIT_SETTING,
    REVERSE_OUTPUT_VOLTAGE_SETTING, INPUT_VOLTAGE_SETTING};

  cics_host u_cics_host (.clk(clk), .nrst(nrst), .fast_mode(fast_mode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_two(cmd_two),
    .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
    .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .busy(busy), .scl_in(scl), .scl_out(scl_o),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_o), .sda_oe_n(sda_oe_n));
  cics_dev_model #(.MAKER(MAKER_V), .PART(PART_V)) u_cics_dev_model (.lclk(lclk),
    .scl(scl), .sda(sda), .stretch(stretch), .scl_oe_n(dscl_oe_n), .sda_oe_n(dsda_oe_n));

  always #25 clk = ~clk;
  initial #7 forever #24 lclk = ~lclk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // expected response, start count and clock pulses follow from the framing
  task automatic cmd(input logic rd, input logic two, input logic [7:0] rg,
    input logic [15:0] wd, input logic nk, input logic er, input logic [15:0] rx);
    cics_exp_t x;
    int c;
    x.nack = nk;
    x.err = er;
    x.rd = rx;
    x.mask = rd ? (two ? 16'hFFFF : 16'h00FF) : 16'h0000;
    x.st = er ? 2'd0 : (rd && !nk) ? 2'd2 : 2'd1;
    x.pulses = er ? 8'd0 : nk ? 8'd19 : 8'(rd ? 38 + 9 * two : 28 + 9 * two);
    exp_q.push_back(x);
    c = rsp_cnt;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_two = two;
    cmd_reg = rg;
    cmd_wdata = wd;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    check("busy after take", {15'h0000, busy}, {15'h0000, !er});
    check("ready after take", {15'h0000, cmd_ready}, {15'h0000, er});
    while (rsp_cnt == c) @(posedge clk);
    #1;
  endtask

  always @(negedge sda) if (scl === 1'b1) starts++;
  always @(negedge scl) pulses++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      end_of_test();
    end else if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected response", 16'h0001, 16'h0000);
      else begin
        e = exp_q.pop_front();
        check("nack", {15'h0000, rsp_nack}, {15'h0000, e.nack});
        check("refused", {15'h0000, rsp_err}, {15'h0000, e.err});
        check("read data", rsp_rdata & e.mask, e.rd);
        check("starts", 16'(starts), 16'(e.st));
        check("clock pulses", 16'(pulses), 16'(e.pulses));
        check("idle lines", {14'h0000, scl, sda}, 16'h0003);
        check("busy at end", {15'h0000, busy}, 16'h0000);
      end
      starts = 0;
      pulses = 0;
      rsp_cnt++;
    end
  end

  initial begin
    clk = 1'b0;
    lclk = 1'b0;
    nrst = 1'b0;
    fast_mode = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_two = 1'b0;
    cmd_reg = 8'h00;
    cmd_wdata = 16'h0000;
    stretch = 4'h0;
    void'($urandom(32'h46dc_ef95));
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    starts = 0;
    pulses = 0;
    cmd(1'b1, 1'b0, MAKER_CODE_REGISTER, 16'h0000, 1'b0, 1'b0, {8'h00, MAKER_V});
    cmd(1'b1, 1'b1, MAKER_CODE_REGISTER, 16'h0000, 1'b0, 1'b0, {PART_V, MAKER_V});
    foreach (pair[i]) begin
      fast_mode = (i != 0);
      stretch = 4'(i * 5);
      kept[i] = 16'($urandom);
      cmd(1'b0, 1'b1, pair[i], kept[i], 1'b0, 1'b0, 16'h0000);
      cmd(1'b1, 1'b1, pair[i], 16'h0000, 1'b0, 1'b0, kept[i]);
    end
    fast_mode = 1'b1;
    d = 16'($urandom);
    // lone high byte and lone low byte are both refused, value stays
    cmd(1'b0, 1'b0, pair[0] + 8'd1, d, 1'b0, 1'b1, 16'h0000);
    cmd(1'b0, 1'b0, pair[0], d, 1'b0, 1'b1, 16'h0000);
    cmd(1'b1, 1'b1, pair[0], 16'h0000, 1'b0, 1'b0, kept[0]);
    cmd(1'b0, 1'b0, 8'h10, d, 1'b1, 1'b0, 16'h0000);
    cmd(1'b1, 1'b0, 8'h1F, 16'h0000, 1'b1, 1'b0, 16'h0000);
    cmd(1'b0, 1'b0, 8'h0C, d, 1'b0, 1'b0, 16'h0000);
    cmd(1'b1, 1'b0, 8'h0C, 16'h0000, 1'b0, 1'b0, {8'h00, d[7:0]});
    cmd(1'b0, 1'b0, MAKER_CODE_REGISTER, d, 1'b0, 1'b0, 16'h0000);
    cmd(1'b1, 1'b0, MAKER_CODE_REGISTER, 16'h0000, 1'b0, 1'b0, {8'h00, MAKER_V});
    end_of_test();
  end
endmodule
`default_nettype wire
